/* File: rtl/clksw_pkg.sv */
// Constants and types for the system clock switch control
//----------------------------------------------------------------
//----------------------------------------------------------------
package clksw_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int PLL_LOCK_US = 2000;
  localparam int PLL_LOCK_CYC = PLL_LOCK_US * (CLK_HZ / 1_000_000);
  localparam int OST_EDGES = 1024;
  localparam int INT_STABLE_EDGES = 16;
  localparam int SEC_STABLE_EDGES = 8;
  localparam int OLD_EDGES = 2;
  localparam int NEW_EDGES = 3;

  localparam int PIN_W = 4;
  localparam int PIN_PRI = 0;
  localparam int PIN_SEC = 1;
  localparam int PIN_FAST = 2;
  localparam int PIN_SLOW = 3;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_AUX = 4'h4;
  localparam logic [3:0] ADDR_PWR = 4'h8;

  localparam int AUX_LFS = 0;
  localparam int AUX_PLL = 1;
  localparam int AUX_SEC_EN = 2;
  localparam int AUX_SEC_RUN = 3;

  localparam logic [1:0] SCS_PRI = 2'h0;
  localparam logic [1:0] SCS_SEC = 2'h1;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_31K = 3'h0;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_1MHZ = 3'h4;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_4MHZ = 3'h6;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_8MHZ = 3'h7;

  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} src_t;
  typedef enum logic [1:0] {
    SW_RUN, SW_WAIT_NEW, SW_OLD_STOP, SW_NEW_START
  } sw_state_t;

  typedef struct packed {
    logic idle;
    logic [2:0] internal_freq_select;
    logic primary_start_done;
    logic internal_freq_stable;
    logic [1:0] clock_source_select;
  } osc_ctrl_t;

  // Postscaler mask: tick when masked count bits are all ones
  function automatic logic [7:0] ps_mask(input logic [2:0] f);
    case (f)
      3'h7: ps_mask = 8'h00;
      3'h6: ps_mask = 8'h01;
      3'h5: ps_mask = 8'h03;
      3'h4: ps_mask = 8'h07;
      3'h3: ps_mask = 8'h0f;
      3'h2: ps_mask = 8'h1f;
      3'h1: ps_mask = 8'h3f;
      default: ps_mask = 8'hff;
    endcase
  endfunction
endpackage

/* File: rtl/sync_2ff.sv */
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/clk_switch_ctrl.sv */
// Clock source switch control with Avalon-MM register slave
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module clk_switch_ctrl
  import clksw_pkg::*;
#(
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC,
  parameter int OST_COUNT = OST_EDGES,
  parameter int INT_SETTLE = INT_STABLE_EDGES,
  parameter int SEC_SETTLE = SEC_STABLE_EDGES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PIN_W-1:0] osc_pins,
  input wire logic sleep_exec,
  input wire logic wake_event,
  input wire logic two_speed_start_cfg,
  input wire logic primary_is_internal,
  output logic cpu_tick,
  output logic periph_tick,
  output logic wdt_tick,
  output logic fast_osc_enable,
  output logic pll_active,
  output logic idle_mode,
  output logic sleep_mode,
  output logic [1:0] sys_src
);
  localparam int OST_W = $clog2(OST_COUNT + 1);
  localparam int PLL_W = $clog2(PLL_LOCK_CYCLES + 1);
  localparam int INT_W = $clog2(INT_SETTLE + 1);
  localparam int SEC_W = $clog2(SEC_SETTLE + 1);

  //--------------------------------------------------------------
  // Oscillator edges
  //--------------------------------------------------------------
  // Sampling limits usable source rate to well below clk / 2
  logic [PIN_W-1:0] osc_sync;
  logic [PIN_W-1:0] osc_prev_ff;
  logic [PIN_W-1:0] osc_rise;

  sync_2ff #(.W(PIN_W)) u_osc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(osc_pins),
    .q(osc_sync)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_prev_ff <= '0;
    end else begin
      osc_prev_ff <= osc_sync;
    end
  end

  assign osc_rise = osc_sync & ~osc_prev_ff;

  //--------------------------------------------------------------
  // Register slave
  //--------------------------------------------------------------
  logic idle_ff;
  logic [2:0] internal_freq_select_ff;
  logic [1:0] scs_ff;
  logic lfs_ff;
  logic pll_en_ff;
  logic sec_en_ff;
  logic primary_start_done_ff;
  logic internal_freq_stable_ff;
  logic secondary_clock_running_ff;
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic bus_req;
  logic bus_fire;
  logic wr_ctrl;
  logic wr_aux;
  logic pll_ok;
  logic [1:0] nxt_scs;
  osc_ctrl_t wctrl;
  osc_ctrl_t ctrl_view;
  sw_state_t state_ff;
  src_t active_ff;
  src_t new_src_ff;
  src_t target;

  assign bus_req = avs_read | avs_write;
  assign bus_fire = bus_req & ~wait_ff;
  assign wr_ctrl = bus_fire & avs_write & (avs_address == ADDR_CTRL);
  assign wr_aux = bus_fire & avs_write & (avs_address == ADDR_AUX);
  assign wctrl = osc_ctrl_t'(avs_writedata[7:0]);

  // One wait cycle per access; answer lands on the next edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
    end else if (bus_req & wait_ff) begin
      wait_ff <= 1'b0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (avs_read & wait_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  always_comb begin
    ctrl_view = '{idle_ff, internal_freq_select_ff, primary_start_done_ff, internal_freq_stable_ff, scs_ff};
    rd_mux = '0;
    case (avs_address)
      ADDR_CTRL: rd_mux = 32'(ctrl_view);
      ADDR_AUX: begin
        rd_mux[AUX_LFS] = lfs_ff;
        rd_mux[AUX_PLL] = pll_en_ff;
        rd_mux[AUX_SEC_EN] = sec_en_ff;
        rd_mux[AUX_SEC_RUN] = secondary_clock_running_ff;
      end
      ADDR_PWR: rd_mux = {29'h0, state_ff != SW_RUN,
        sleep_mode, idle_mode};
      default: rd_mux = '0;
    endcase
  end

  // Secondary select refused while its oscillator is off
  assign nxt_scs = (wctrl.clock_source_select == SCS_SEC && !sec_en_ff) ?
    scs_ff : wctrl.clock_source_select;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_ff <= 1'b0;
      internal_freq_select_ff <= INTERNAL_FREQ_SELECT_1MHZ;
      scs_ff <= SCS_PRI;
    end else if (wr_ctrl) begin
      idle_ff <= wctrl.idle;
      internal_freq_select_ff <= wctrl.internal_freq_select;
      scs_ff <= nxt_scs;
    end
  end

  assign pll_ok = primary_is_internal &
    (internal_freq_select_ff == INTERNAL_FREQ_SELECT_8MHZ || internal_freq_select_ff == INTERNAL_FREQ_SELECT_4MHZ);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lfs_ff <= 1'b0;
      sec_en_ff <= 1'b0;
    end else if (wr_aux) begin
      lfs_ff <= avs_writedata[AUX_LFS];
      sec_en_ff <= avs_writedata[AUX_SEC_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pll_en_ff <= 1'b0;
    end else if (!pll_ok) begin
      pll_en_ff <= 1'b0;
    end else if (wr_aux) begin
      pll_en_ff <= avs_writedata[AUX_PLL];
    end
  end

  //--------------------------------------------------------------
  // Source ticks and postscaler
  //--------------------------------------------------------------
  logic use_slow;
  logic fast_en_ff;
  logic [7:0] ps_cnt_ff;
  logic fast_tick;
  logic slow_tick;
  logic ps_hit;
  logic int_tick;
  logic pri_tick;
  logic sec_tick;

  assign use_slow = (internal_freq_select_ff == INTERNAL_FREQ_SELECT_31K) && !lfs_ff;
  assign slow_tick = osc_rise[PIN_SLOW];
  assign fast_tick = osc_rise[PIN_FAST] & fast_en_ff;
  // Mask follows the field directly, so a rate change is immediate
  assign ps_hit = fast_tick &
    ((ps_cnt_ff & ps_mask(internal_freq_select_ff)) == ps_mask(internal_freq_select_ff));
  assign int_tick = use_slow ? slow_tick : ps_hit;
  assign pri_tick = primary_is_internal ? int_tick : osc_rise[PIN_PRI];
  assign sec_tick = osc_rise[PIN_SEC] & sec_en_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fast_en_ff <= 1'b1;
      ps_cnt_ff <= '0;
    end else begin
      fast_en_ff <= !use_slow;
      if (fast_tick) begin
        ps_cnt_ff <= ps_cnt_ff + 8'h01;
      end
    end
  end

  function automatic logic tick_of(input src_t s, input logic p,
    input logic c, input logic i);
    case (s)
      SRC_PRI: tick_of = p;
      SRC_SEC: tick_of = c;
      SRC_INT: tick_of = i;
      default: tick_of = 1'b0;
    endcase
  endfunction

  //--------------------------------------------------------------
  // Start-up and settle timers
  //--------------------------------------------------------------
  logic [OST_W-1:0] ost_cnt_ff;
  logic [PLL_W-1:0] pll_cnt_ff;
  logic [INT_W-1:0] int_cnt_ff;
  logic [SEC_W-1:0] sec_cnt_ff;
  logic ost_done_ff;
  logic pll_ready_ff;
  logic int_ok_ff;
  logic sec_ok_ff;
  logic pri_ok;
  logic new_ok;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ost_cnt_ff <= '0;
      ost_done_ff <= 1'b0;
    end else if (primary_is_internal) begin
      ost_done_ff <= 1'b1;
    end else if (osc_rise[PIN_PRI] && !ost_done_ff) begin
      ost_cnt_ff <= ost_cnt_ff + OST_W'(1);
      ost_done_ff <= ost_cnt_ff == OST_W'(OST_COUNT - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !pll_en_ff) begin
      pll_cnt_ff <= '0;
      pll_ready_ff <= 1'b0;
    end else if (!pll_ready_ff) begin
      pll_cnt_ff <= pll_cnt_ff + PLL_W'(1);
      pll_ready_ff <= pll_cnt_ff == PLL_W'(PLL_LOCK_CYCLES - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || !fast_en_ff) begin
      int_cnt_ff <= '0;
      int_ok_ff <= 1'b0;
    end else if (fast_tick && !int_ok_ff) begin
      int_cnt_ff <= int_cnt_ff + INT_W'(1);
      int_ok_ff <= int_cnt_ff == INT_W'(INT_SETTLE - 1);
    end
  end

  // Unsettled secondary stalls the switch; software starts it early
  always_ff @(posedge clk) begin
    if (!rst_n || !sec_en_ff) begin
      sec_cnt_ff <= '0;
      sec_ok_ff <= 1'b0;
    end else if (sec_tick && !sec_ok_ff) begin
      sec_cnt_ff <= sec_cnt_ff + SEC_W'(1);
      sec_ok_ff <= sec_cnt_ff == SEC_W'(SEC_SETTLE - 1);
    end
  end

  assign pri_ok = ost_done_ff && (!pll_en_ff || pll_ready_ff) &&
    (!primary_is_internal || use_slow || int_ok_ff);
  assign new_ok = tick_of(target, pri_ok, sec_ok_ff,
    use_slow || int_ok_ff);

  //--------------------------------------------------------------
  // Glitch-free switch
  //--------------------------------------------------------------
  logic [1:0] edge_cnt_ff;
  logic old_tick;
  logic new_tick;
  logic dev_tick;

  assign target = scs_ff[1] ? SRC_INT :
    (scs_ff[0] ? SRC_SEC : SRC_PRI);
  assign old_tick = tick_of(active_ff, pri_tick, sec_tick, int_tick);
  assign new_tick = tick_of(new_src_ff, pri_tick, sec_tick, int_tick);
  // Old clock keeps running while the new one settles
  assign dev_tick = old_tick &&
    (state_ff == SW_RUN || state_ff == SW_WAIT_NEW);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= SW_RUN;
      active_ff <= SRC_PRI;
      new_src_ff <= SRC_PRI;
      edge_cnt_ff <= '0;
    end else begin
      case (state_ff)
        SW_RUN: begin
          if (target != active_ff) begin
            state_ff <= SW_WAIT_NEW;
          end
        end
        SW_WAIT_NEW: begin
          if (target == active_ff) begin
            state_ff <= SW_RUN;
          end else if (new_ok) begin
            state_ff <= SW_OLD_STOP;
            new_src_ff <= target;
            edge_cnt_ff <= '0;
          end
        end
        SW_OLD_STOP: begin
          if (old_tick) begin
            edge_cnt_ff <= edge_cnt_ff + 2'h1;
            if (edge_cnt_ff == 2'(OLD_EDGES - 1)) begin
              state_ff <= SW_NEW_START;
              edge_cnt_ff <= '0;
            end
          end
        end
        SW_NEW_START: begin
          if (new_tick) begin
            edge_cnt_ff <= edge_cnt_ff + 2'h1;
            if (edge_cnt_ff == 2'(NEW_EDGES - 1)) begin
              state_ff <= SW_RUN;
              active_ff <= new_src_ff;
              edge_cnt_ff <= '0;
            end
          end
        end
        default: state_ff <= SW_RUN;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Status flags
  //--------------------------------------------------------------
  logic running;

  assign running = state_ff == SW_RUN;

  // Flags are exclusive because each needs its own active source
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      primary_start_done_ff <= !two_speed_start_cfg;
      internal_freq_stable_ff <= 1'b0;
      secondary_clock_running_ff <= 1'b0;
    end else begin
      primary_start_done_ff <= pri_ok && running && active_ff == SRC_PRI;
      internal_freq_stable_ff <= int_ok_ff && !use_slow && running &&
        active_ff == SRC_INT;
      secondary_clock_running_ff <= running && active_ff == SRC_SEC;
    end
  end

  //--------------------------------------------------------------
  // Power modes and outputs
  //--------------------------------------------------------------
  // Sleep action wins over a wake in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      idle_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end else if (sleep_exec) begin
      idle_mode <= idle_ff;
      sleep_mode <= !idle_ff;
    end else if (wake_event) begin
      idle_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cpu_tick <= 1'b0;
      periph_tick <= 1'b0;
      wdt_tick <= 1'b0;
      fast_osc_enable <= 1'b1;
      pll_active <= 1'b0;
      sys_src <= SCS_PRI;
    end else begin
      cpu_tick <= dev_tick && !idle_mode && !sleep_mode;
      periph_tick <= dev_tick && !sleep_mode;
      wdt_tick <= slow_tick;
      fast_osc_enable <= fast_en_ff;
      pll_active <= pll_en_ff && pll_ready_ff;
      sys_src <= active_ff;
    end
  end

  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;

  //--------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_src_decode: assert property (
    running && $past(running) && $stable(scs_ff) |->
    active_ff == (scs_ff[1] ? SRC_INT : scs_ff[0] ? SRC_SEC : SRC_PRI))
    else $error("active source differs from select field");
  chk_sel_switch: assert property (
    running && target != active_ff |=> state_ff == SW_WAIT_NEW)
    else $error("select change did not start a switch");
  chk_reset_sel: assert property (
    $rose(rst_n) |-> scs_ff == SCS_PRI && active_ff == SRC_PRI)
    else $error("select not primary after reset");
  chk_reset_freq: assert property (
    $rose(rst_n) |-> internal_freq_select_ff == INTERNAL_FREQ_SELECT_1MHZ)
    else $error("frequency field not 1 MHz after reset");
  chk_post_direct: assert property (
    internal_freq_select_ff == INTERNAL_FREQ_SELECT_8MHZ |-> ps_hit == fast_tick)
    else $error("8 MHz code not direct");
  chk_slow_sel: assert property (
    use_slow |=> !fast_en_ff ##1 !fast_osc_enable)
    else $error("fast oscillator left on for slow source");
  chk_wdt_slow: assert property (
    slow_tick |=> wdt_tick)
    else $error("watchdog tick lost");
  chk_primary_start_done_cause: assert property (
    primary_start_done_ff && $past(rst_n) |->
    $past(ost_done_ff) && $past(active_ff) == SRC_PRI)
    else $error("primary done flag without cause");
  chk_primary_start_done_reset: assert property (
    $rose(rst_n) |-> primary_start_done_ff == !two_speed_start_cfg)
    else $error("primary done flag reset value wrong");
  chk_internal_freq_stable_cause: assert property (
    internal_freq_stable_ff |-> $past(int_ok_ff) && !$past(use_slow))
    else $error("internal stable flag without cause");
  chk_flag_onehot: assert property (
    $onehot0({primary_start_done_ff, internal_freq_stable_ff, secondary_clock_running_ff}))
    else $error("more than one source flag set");
  chk_sleep_pick: assert property (
    sleep_exec && !idle_ff |=> sleep_mode && !idle_mode)
    else $error("sleep mode not entered");
  chk_sec_ignore: assert property (
    wr_ctrl && wctrl.clock_source_select == SCS_SEC && !sec_en_ff |=> $stable(scs_ff))
    else $error("secondary select taken while off");
  chk_pause_old: assert property (
    state_ff == SW_OLD_STOP || state_ff == SW_NEW_START |=> !cpu_tick)
    else $error("device clock ran during pause");
  chk_ost_count: assert property (
    $rose(ost_done_ff) && !primary_is_internal |->
    ost_cnt_ff == OST_W'(OST_COUNT))
    else $error("start-up timer count wrong");
  chk_pll_gate: assert property (
    !pll_ok |=> !pll_en_ff)
    else $error("PLL enable held outside allowed modes");
  chk_wait_new: assert property (
    state_ff == SW_WAIT_NEW && !new_ok |=> state_ff != SW_OLD_STOP)
    else $error("handover before new source stable");

  cov_to_sec: cover property (
    state_ff == SW_NEW_START && new_src_ff == SRC_SEC ##2 secondary_clock_running_ff);
  cov_to_int: cover property (
    state_ff == SW_NEW_START ##1 running && active_ff == SRC_INT);
  cov_idle: cover property (sleep_exec && idle_ff ##1 idle_mode);
  cov_sleep: cover property (sleep_exec && !idle_ff ##1 sleep_mode);
endmodule
`default_nettype wire

/* File: testbench/osc_model.sv */
// Behavioural oscillator sources feeding the clock switch pins
`timescale 1ns/1ps
`default_nettype none
module osc_model (
  input wire logic clk,
  input wire logic sec_on,
  input wire logic fast_on,
  output logic [3:0] pins
);
  // Half periods in clk cycles: primary, secondary, fast, slow
  function automatic int half_of(input int i);
    case (i)
      1: half_of = 3;
      3: half_of = 4;
      default: half_of = 2;
    endcase
  endfunction
  int cnt [4];
  logic [3:0] run;
  // Slow source never stops: the watchdog needs it
  assign run = {1'b1, fast_on, sec_on, 1'b1};
  initial begin
    pins = 4'h0;
    foreach (cnt[i]) cnt[i] = 0;
  end
  // A stopped source rests low, as a dead crystal would
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!run[i]) begin
        cnt[i] <= 0;
        pins[i] <= 1'b0;
      end else if (cnt[i] == half_of(i) - 1) begin
        cnt[i] <= 0;
        pins[i] <= ~pins[i];
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_system_clock_switch_control.sv */
// Register level tests of the clock switch control
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_switch_control;
  import clksw_pkg::*;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, sec_on;
  logic [3:0] avs_address, osc_pins;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic sleep_exec, wake_event, two_speed_start_cfg, primary_is_internal;
  logic cpu_tick, periph_tick, wdt_tick, fast_osc_enable, pll_active;
  logic idle_mode, sleep_mode;
  logic [1:0] sys_src;
  int error_cnt = 0;
  int n_tests = 0;
  int p;
  int q;

  clk_switch_ctrl #(.PLL_LOCK_CYCLES(20), .OST_COUNT(8), .INT_SETTLE(2),
    .SEC_SETTLE(2)) DUT (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .osc_pins(osc_pins), .sleep_exec(sleep_exec),
    .wake_event(wake_event), .two_speed_start_cfg(two_speed_start_cfg),
    .primary_is_internal(primary_is_internal), .cpu_tick(cpu_tick),
    .periph_tick(periph_tick), .wdt_tick(wdt_tick),
    .fast_osc_enable(fast_osc_enable), .pll_active(pll_active),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode), .sys_src(sys_src));

  osc_model osc (.clk(clk), .sec_on(sec_on), .fast_on(fast_osc_enable),
    .pins(osc_pins));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Request held until waitrequest sampled low, then one idle edge
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    if (n >= 100) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [3:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic wait_src(input logic [1:0] s);
    int n;
    n = 0;
    while (sys_src !== s && n < 3000) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    chk("sys_src", {30'h0, s}, {30'h0, sys_src});
  endtask

  // Interval between two later pulses of cpu_tick or wdt_tick
  task automatic per(input logic w, output int q);
    int n;
    n = 0;
    repeat (3) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((w ? wdt_tick : cpu_tick) !== 1'b1 && n < 3000);
    end
    q = n;
  endtask

  task automatic pulse_sleep(input logic s);
    if (s) sleep_exec <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    wake_event <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Counts cpu_tick and periph_tick pulses over 64 cycles
  task automatic ticks(output int nc, output int np);
    nc = 0;
    np = 0;
    repeat (64) begin
      @(posedge clk);
      nc += cpu_tick;
      np += periph_tick;
    end
  endtask

  initial begin
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    sleep_exec = 1'b0;
    wake_event = 1'b0;
    two_speed_start_cfg = 1'b1;
    primary_is_internal = 1'b0;
    sec_on = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("ctrl reset", ADDR_CTRL, 32'h0000_0040);
    rdchk("aux reset", ADDR_AUX, 32'h0000_0000);
    $display("test reset done");
    repeat (120) @(posedge clk);
    rdchk("ctrl ost", ADDR_CTRL, 32'h0000_0048);
    bus(1'b1, ADDR_CTRL, 32'h0000_0044);
    rdchk("ctrl ro flags", ADDR_CTRL, 32'h0000_0048);
    bus(1'b1, 4'hc, 32'h0000_00ff);
    rdchk("unmapped", 4'hc, 32'h0000_0000);
    $display("test primary done");
    bus(1'b1, ADDR_CTRL, 32'h0000_0041);
    rdchk("ctrl sec refused", ADDR_CTRL, 32'h0000_0048);
    wait_src(2'h0);
    sec_on <= 1'b1;
    bus(1'b1, ADDR_AUX, 32'h0000_0004);
    repeat (60) @(posedge clk);
    bus(1'b1, ADDR_CTRL, 32'h0000_0041);
    wait_src(2'h1);
    rdchk("ctrl sec", ADDR_CTRL, 32'h0000_0041);
    rdchk("aux sec run", ADDR_AUX, 32'h0000_000c);
    $display("test secondary done");
    bus(1'b1, ADDR_CTRL, 32'h0000_0072);
    wait_src(2'h2);
    rdchk("ctrl int", ADDR_CTRL, 32'h0000_0076);
    rdchk("aux int", ADDR_AUX, 32'h0000_0004);
    bus(1'b1, ADDR_AUX, 32'h0000_0006);
    rdchk("pll refused", ADDR_AUX, 32'h0000_0004);
    primary_is_internal <= 1'b1;
    bus(1'b1, ADDR_AUX, 32'h0000_0006);
    rdchk("pll taken", ADDR_AUX, 32'h0000_0006);
    repeat (24) @(posedge clk);
    chk("pll lock", 32'h1, {31'h0, pll_active});
    bus(1'b1, ADDR_AUX, 32'h0000_0004);
    bus(1'b1, ADDR_CTRL, 32'h0000_0052);
    chk("pll off", 32'h0, {31'h0, pll_active});
    bus(1'b1, ADDR_AUX, 32'h0000_0006);
    rdchk("pll low freq", ADDR_AUX, 32'h0000_0004);
    primary_is_internal <= 1'b0;
    $display("test internal done");
    for (int c = 7; c >= 1; c--) begin
      bus(1'b1, ADDR_CTRL, {24'h0, 1'b0, 3'(c), 4'h2});
      per(1'b0, p);
      chk("tick period", 32'd4 << (7 - c), 32'(p));
    end
    bus(1'b1, ADDR_AUX, 32'h0000_0005);
    bus(1'b1, ADDR_CTRL, 32'h0000_0002);
    per(1'b0, p);
    chk("period 31k fast", 32'd1024, 32'(p));
    chk("fast on", 32'h1, {31'h0, fast_osc_enable});
    per(1'b1, p);
    chk("wdt period", 32'd8, 32'(p));
    bus(1'b1, ADDR_AUX, 32'h0000_0004);
    per(1'b0, p);
    chk("period 31k slow", 32'd8, 32'(p));
    chk("fast off", 32'h0, {31'h0, fast_osc_enable});
    rdchk("ctrl no flag", ADDR_CTRL, 32'h0000_0002);
    $display("test frequency done");
    bus(1'b1, ADDR_CTRL, 32'h0000_00f2);
    pulse_sleep(1'b1);
    rdchk("power idle", ADDR_PWR, 32'h0000_0001);
    ticks(p, q);
    chk("idle cpu", 32'h0, 32'(p));
    chk("idle periph", 32'h1, {31'h0, q >= 12});
    pulse_sleep(1'b0);
    bus(1'b1, ADDR_CTRL, 32'h0000_0072);
    pulse_sleep(1'b1);
    rdchk("power sleep", ADDR_PWR, 32'h0000_0002);
    ticks(p, q);
    chk("sleep ticks", 32'h0, 32'(p + q));
    pulse_sleep(1'b0);
    $display("test sleep done");
    bus(1'b1, ADDR_CTRL, 32'h0000_0040);
    wait_src(2'h0);
    rdchk("ctrl back pri", ADDR_CTRL, 32'h0000_0048);
    bus(1'b1, ADDR_CTRL, 32'h0000_0072);
    wait_src(2'h2);
    rst_n <= 1'b0;
    two_speed_start_cfg <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("src after reset", 32'h0, {30'h0, sys_src});
    rdchk("ctrl rereset", ADDR_CTRL, 32'h0000_0040);
    $display("test mid reset done");
    conclude();
  end

  // Whole sequence needs well under 20000 cycles
  initial begin
    #1_000_000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
